// ### verilog/scsg_sleep_control.sv
// Sleep control sequencer with SMI status/enable group behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module scsg_sleep_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scsg_pkg::SCSG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_clk_32k,
  input wire logic gpio_source_a,
  input wire logic gpio_source_b,
  input wire logic gpio_source_c,
  input wire logic gpio_source_d,
  input wire logic gpio_source_e,
  input wire logic kbc_port_line,
  output logic power_supply_on_n_out,
  output logic power_supply_on_n_oe_n,
  output logic [2:0] sleep_state_type,
  output logic sleep_state_enter,
  output logic grouped_smi_out_n,
  output logic irq
);

  // APB decode
  wire logic setup_phase = psel & ~penable;
  wire logic access_phase = psel & penable & pready;
  wire logic word_ok = (paddr[1:0] == 2'b00);
  // Full word index is compared so upper address bits cannot alias a register
  wire logic [scsg_pkg::SCSG_ADDR_W-3:0] reg_idx = paddr[scsg_pkg::SCSG_ADDR_W-1:2];
  wire logic hit_slp = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_SLEEP_CTRL));
  wire logic hit_sts = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_SMI_STS));
  wire logic hit_en = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_SMI_EN));
  wire logic hit_pwr = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_PWR_CTRL));
  wire logic hit_evs = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_EVT_STS));
  wire logic hit_evm = word_ok && (reg_idx == (scsg_pkg::SCSG_ADDR_W-2)'(scsg_pkg::SCSG_IDX_EVT_MASK));
  wire logic hit_any = hit_slp | hit_sts | hit_en | hit_pwr | hit_evs | hit_evm;
  wire logic wr_lane0 = access_phase & pwrite & pstrb[0] & hit_any;
  wire logic [7:0] wbyte = pwdata[7:0];
  // Per-register write strobes, all qualified by lane 0
  wire logic wr_slp = wr_lane0 & hit_slp;
  wire logic wr_sts = wr_lane0 & hit_sts;
  wire logic wr_en = wr_lane0 & hit_en;
  wire logic wr_pwr = wr_lane0 & hit_pwr;
  wire logic wr_evs = wr_lane0 & hit_evs;
  wire logic wr_evm = wr_lane0 & hit_evm;
  // Read data is captured at setup, so reads decode in that phase
  wire logic rd_setup = setup_phase & ~pwrite;

  // Register state
  logic [2:0] slp_type_q;
  logic [7:0] smi_sts_q;
  wire logic [7:0] smi_sts_d;
  logic [7:0] smi_en_q;
  logic sel_smi_q;
  logic [2:0] evt_sts_q;
  wire logic [2:0] evt_sts_d;
  logic [2:0] evt_mask_q;
  logic [7:0] src_prev_q;
  logic rtc_s1_q;
  logic rtc_s2_q;
  logic rtc_s3_q;
  logic [2:0] seq_type_q;
  scsg_pkg::scsg_state_e state_q;
  scsg_pkg::scsg_state_e state_d;
  logic [31:0] prdata_d;

  // Sleep request: only a written one counts
  wire logic slp_req = wr_lane0 & hit_slp & wbyte[scsg_pkg::SCSG_SLP_REQ_BIT];
  wire logic [2:0] wr_type = wbyte[scsg_pkg::SCSG_SLP_TYPE_MSB:scsg_pkg::SCSG_SLP_TYPE_LSB];
  // Divert to SMI when selector set
  wire logic slp_go = slp_req & ~sel_smi_q & (state_q == scsg_pkg::SCSG_ST_IDLE);
  wire logic slp_divert = slp_req & sel_smi_q;
  wire logic type_off = (seq_type_q == scsg_pkg::SCSG_SLP_TYPE_OFF_A) ||
                        (seq_type_q == scsg_pkg::SCSG_SLP_TYPE_OFF_B);

  // RTC clock edges; first stage only feeds the second
  wire logic rtc_rise = rtc_s2_q & ~rtc_s3_q;

  // SMI sources in status layout
  wire logic [7:0] src_now = {gpio_source_e, 1'b0, 1'b0, kbc_port_line,
                              gpio_source_d, gpio_source_c, gpio_source_b, gpio_source_a};
  wire logic [7:0] src_rise = src_now & ~src_prev_q;
  wire logic [7:0] smi_set = src_rise | ({7'h00, slp_req} << scsg_pkg::SCSG_SMI_SLP_BIT);
  wire logic [7:0] smi_clr = wr_sts ? wbyte : 8'h00;
  wire logic [7:0] smi_pend_d;

  // One status flop per source; set wins over a clear in the same cycle
  for (genvar b = 0; b < 8; b++) begin : g_sts_bit
    wire logic impl = scsg_pkg::SCSG_SMI_IMPL_MASK[b];
    wire logic keep = smi_sts_q[b] & ~smi_clr[b];
    assign smi_sts_d[b] = (keep | smi_set[b]) & impl;
    assign smi_pend_d[b] = smi_sts_d[b] & smi_en_q[b];
  end

  // Sequencer: count two RTC rising edges, i.e. one to two RTC periods
  always_comb begin
    state_d = state_q;
    case (state_q)
      scsg_pkg::SCSG_ST_IDLE: begin
        if (slp_go) begin
          state_d = scsg_pkg::SCSG_ST_WAIT1;
        end
      end
      scsg_pkg::SCSG_ST_WAIT1: begin
        if (rtc_rise) begin
          state_d = scsg_pkg::SCSG_ST_WAIT2;
        end
      end
      scsg_pkg::SCSG_ST_WAIT2: begin
        if (rtc_rise) begin
          state_d = type_off ? scsg_pkg::SCSG_ST_OFF : scsg_pkg::SCSG_ST_IDLE;
        end
      end
      scsg_pkg::SCSG_ST_OFF: begin
        // Off holds until reset; power returns from outside
        state_d = scsg_pkg::SCSG_ST_OFF;
      end
      default: begin
        state_d = scsg_pkg::SCSG_ST_IDLE;
      end
    endcase
  end

  wire logic seq_done = (state_q == scsg_pkg::SCSG_ST_WAIT2) & rtc_rise;
  wire logic go_off = seq_done & type_off;
  wire logic go_sleep = seq_done & ~type_off;

  wire logic [2:0] evt_set = {slp_divert, go_sleep, go_off};
  wire logic [2:0] evt_clr = wr_evs ? wbyte[2:0] : 3'h0;
  // Event flags: set wins over a clear in the same cycle
  for (genvar e = 0; e < 3; e++) begin : g_evt_bit
    assign evt_sts_d[e] = (evt_sts_q[e] & ~evt_clr[e]) | evt_set[e];
  end

  // Read mux; bit 5 and bits 1:0, 7:6 read zero
  wire logic [7:0] rd_slp = {3'h0, slp_type_q, 2'h0} & scsg_pkg::SCSG_SLEEP_CTRL_RMASK;
  wire logic [7:0] rd_pwr = {5'h00, state_q, sel_smi_q};
  always_comb begin
    if (hit_slp) begin
      prdata_d = {24'h000000, rd_slp};
    end else if (hit_sts) begin
      prdata_d = {24'h000000, smi_sts_q};
    end else if (hit_en) begin
      prdata_d = {24'h000000, smi_en_q};
    end else if (hit_pwr) begin
      prdata_d = {24'h000000, rd_pwr};
    end else if (hit_evs) begin
      prdata_d = {29'h00000000, evt_sts_q};
    end else if (hit_evm) begin
      prdata_d = {29'h00000000, evt_mask_q};
    end else begin
      prdata_d = 32'h00000000;
    end
  end

  // APB answer: ready in the first access cycle, never held off
  wire logic pready_d = setup_phase;
  wire logic pslverr_d = setup_phase & ~hit_any;
  wire logic [31:0] rdata_d = rd_setup ? prdata_d : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= rdata_d;
    end
  end

  // Register next values; each holds unless its own write strobe fires, seq_type_d unless slp_go fires
  logic [2:0] slp_type_d;
  logic [7:0] smi_en_d;
  logic sel_smi_d;
  logic [2:0] evt_mask_d;
  logic [2:0] seq_type_d;

  always_comb begin
    slp_type_d = slp_type_q;
    if (wr_slp) begin
      slp_type_d = wr_type;
    end
  end

  always_comb begin
    smi_en_d = smi_en_q;
    if (wr_en) begin
      smi_en_d = wbyte & scsg_pkg::SCSG_SMI_IMPL_MASK;
    end
  end

  always_comb begin
    sel_smi_d = sel_smi_q;
    if (wr_pwr) begin
      sel_smi_d = wbyte[scsg_pkg::SCSG_PWR_SEL_BIT];
    end
  end

  always_comb begin
    evt_mask_d = evt_mask_q;
    if (wr_evm) begin
      evt_mask_d = wbyte[2:0];
    end
  end

  // The type is frozen at request so a later rewrite cannot retarget it
  always_comb begin
    seq_type_d = seq_type_q;
    if (slp_go) begin
      seq_type_d = wr_type;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_type_q <= 3'h0;
    end else begin
      slp_type_q <= slp_type_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_en_q <= scsg_pkg::SCSG_RESET_VAL;
    end else begin
      smi_en_q <= smi_en_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_smi_q <= 1'b0;
    end else begin
      sel_smi_q <= sel_smi_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_q <= 3'h0;
    end else begin
      evt_mask_q <= evt_mask_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_sts_q <= scsg_pkg::SCSG_RESET_VAL;
    end else begin
      smi_sts_q <= smi_sts_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sts_q <= 3'h0;
    end else begin
      evt_sts_q <= evt_sts_d;
    end
  end

  // Cleared to low, so a source already high at release counts as an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 8'h00;
    end else begin
      src_prev_q <= src_now;
    end
  end

  // Three-stage chain; only the second stage reads the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_s1_q <= 1'b0;
      rtc_s2_q <= 1'b0;
      rtc_s3_q <= 1'b0;
    end else begin
      rtc_s1_q <= rtc_clk_32k;
      rtc_s2_q <= rtc_s1_q;
      rtc_s3_q <= rtc_s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= scsg_pkg::SCSG_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_type_q <= 3'h0;
    end else begin
      seq_type_q <= seq_type_d;
    end
  end

  // Output next values; every output leaves straight from a flop
  wire logic oe_n_d = power_supply_on_n_oe_n | go_off;
  wire logic [2:0] type_out_d = seq_done ? seq_type_q : sleep_state_type;
  wire logic smi_n_d = ~|smi_pend_d;
  wire logic irq_d = |(evt_sts_d & evt_mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_supply_on_n_out <= 1'b0;
    end else begin
      power_supply_on_n_out <= 1'b0;
    end
  end

  // Supply stays driven low until off, then floats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_supply_on_n_oe_n <= 1'b0;
    end else begin
      power_supply_on_n_oe_n <= oe_n_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_type <= 3'h0;
    end else begin
      sleep_state_type <= type_out_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_enter <= 1'b0;
    end else begin
      sleep_state_enter <= go_sleep;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grouped_smi_out_n <= 1'b1;
    end else begin
      grouped_smi_out_n <= smi_n_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

endmodule : scsg_sleep_control
`default_nettype wire

// ### verilog/scsg_pkg.sv
// Constants and register map for the sleep control and SMI group block
//
// Summary of operation
// - Sleep control bits 1:0 and 7:6 always read as zero.
// - Bits 4:2 of sleep control hold the three-bit sleep type field.
// - Sleep type 111 or 110 with a sleep request moves machine to off.
// - Power supply on output floats one to two 32 kHz periods after request.
// - Other sleep types leave the power supply on output untouched.
// - Sleep request bit 5 is write-only and always reads zero.
// - Request with selector clear sequences into sleep after one to two RTC clocks.
// - Request with selector set raises an SMI instead of sleeping.
// - Every request sets the sleep request SMI status flag.
// - Writing zero to the sleep request bit does nothing.
// - SMI status register latches rising edges of its source inputs.
// - SMI status bits clear on writing one; zero leaves them alone.
// - Status layout: pins 0-3, kbc line 4, sleep 5, reserved 6, pin 7.
// - SMI enable uses status layout and gates sources onto grouped SMI output.
`default_nettype none
package scsg_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] SCSG_IDX_SLEEP_CTRL = 8'h61;
  localparam logic [7:0] SCSG_IDX_SMI_STS = 8'h64;
  localparam logic [7:0] SCSG_IDX_SMI_EN = 8'h66;
  localparam logic [7:0] SCSG_IDX_PWR_CTRL = 8'h62;
  localparam logic [7:0] SCSG_IDX_EVT_STS = 8'h63;
  localparam logic [7:0] SCSG_IDX_EVT_MASK = 8'h65;
  localparam int SCSG_ADDR_W = 12;
  // Sleep control fields
  localparam int SCSG_SLP_TYPE_LSB = 2;
  localparam int SCSG_SLP_TYPE_MSB = 4;
  localparam int SCSG_SLP_REQ_BIT = 5;
  localparam logic [2:0] SCSG_SLP_TYPE_OFF_A = 3'h7;
  localparam logic [2:0] SCSG_SLP_TYPE_OFF_B = 3'h6;
  localparam logic [7:0] SCSG_SLEEP_CTRL_RMASK = 8'h1c;
  // SMI group layout
  localparam int SCSG_SMI_KBC_BIT = 4;
  localparam int SCSG_SMI_SLP_BIT = 5;
  localparam int SCSG_SMI_GPIO_E_BIT = 7;
  localparam logic [7:0] SCSG_SMI_IMPL_MASK = 8'hbf;
  // Power control and event register fields
  localparam int SCSG_PWR_SEL_BIT = 0;
  localparam int SCSG_EVT_OFF_BIT = 0;
  localparam int SCSG_EVT_SLEEP_BIT = 1;
  localparam int SCSG_EVT_DIVERT_BIT = 2;
  localparam logic [7:0] SCSG_RESET_VAL = 8'h00;
  // RTC timing: wait for this many RTC rising edges, giving one to two periods
  localparam real SCSG_RTC_PERIOD_US = 31.25;
  localparam logic [1:0] SCSG_RTC_EDGES = 2'h2;
  typedef enum logic [1:0] {
    SCSG_ST_IDLE = 2'b00,
    SCSG_ST_WAIT1 = 2'b01,
    SCSG_ST_WAIT2 = 2'b11,
    SCSG_ST_OFF = 2'b10
  } scsg_state_e;
endpackage : scsg_pkg
`default_nettype wire

// ### testbench/scsg_sleep_control_assertions.sv
// Port-level checks for the sleep control and SMI group
`timescale 1ns/1ps
`default_nettype none
module scsg_sleep_control_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic gpio_source_a,
  input wire logic power_supply_on_n_out,
  input wire logic power_supply_on_n_oe_n,
  input wire logic sleep_state_enter,
  input wire logic grouped_smi_out_n
);
  logic [7:0] en_q;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite && pstrb[0];
  wire rdc = acc && !pwrite && paddr == 12'h184;
  wire rde = acc && !pwrite && paddr == 12'h198;
  // Shadow of the enable register, so smi checks know their gate
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_q <= 8'h00;
    else if (wr && paddr == 12'h198) en_q <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req;
    wr && paddr == 12'h184 && pwdata[5];
  endsequence
  a_ctrl_read_zero: assert property (rdc |-> prdata[7:5] == 3'h0 && prdata[1:0] == 2'h0)
    else $error("ctrl fixed bits set");
  a_en_bit6_zero: assert property (rde |-> !prdata[6])
    else $error("enable bit 6 set");
  a_gpio_smi_low: assert property ($rose(gpio_source_a) && en_q[0] |-> ##[1:3] !grouped_smi_out_n)
    else $error("gpio did not raise smi");
  a_sleep_smi_low: assert property (s_req and en_q[5] |-> ##[1:2] !grouped_smi_out_n)
    else $error("request did not raise smi");
  a_smi_idle_high: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> grouped_smi_out_n)
    else $error("smi low while disabled");
  a_off_stays: assert property ($past(power_supply_on_n_oe_n) |-> power_supply_on_n_oe_n)
    else $error("off state left");
  a_pin_drive_low: assert property (!power_supply_on_n_out)
    else $error("supply pin drive high");
  a_enter_pulse: assert property (sleep_state_enter |=> !sleep_state_enter)
    else $error("enter pulse too long");
  a_enter_not_off: assert property (sleep_state_enter |-> !power_supply_on_n_oe_n)
    else $error("enter while off");
endmodule : scsg_sleep_control_assertions
bind scsg_sleep_control scsg_sleep_control_assertions u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .gpio_source_a,
  .power_supply_on_n_out, .power_supply_on_n_oe_n, .sleep_state_enter, .grouped_smi_out_n);
`default_nettype wire

// ### testbench/scsg_sleep_control_tb.sv
// Self-checking bench for the sleep control and SMI group
`timescale 1ns/1ps
`default_nettype none
module scsg_sleep_control_tb;
  logic pclk, presetn, psel, penable, pwrite, rtc_clk_32k, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [5:0] src;
  logic pready, pslverr, ps_out, oe_n, enter, smi_n, irq;
  logic [2:0] stype;
  int error_cnt, compares, cyc, n, m, t;
  scsg_sleep_control u_scsg_sleep_control (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rtc_clk_32k,
    .gpio_source_a(src[0]), .gpio_source_b(src[1]), .gpio_source_c(src[2]),
    .gpio_source_d(src[3]), .gpio_source_e(src[4]), .kbc_port_line(src[5]),
    .power_supply_on_n_out(ps_out), .power_supply_on_n_oe_n(oe_n),
    .sleep_state_type(stype), .sleep_state_enter(enter), .grouped_smi_out_n(smi_n), .irq);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Odd start offset keeps the RTC edges away from pclk edges
  initial begin
    rtc_clk_32k = 1'b0;
    #7;
    forever #15625 rtc_clk_32k = ~rtc_clk_32k;
  end
  task automatic tally_and_finish();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rchk
  function automatic logic [7:0] sts_of(input logic [5:0] s);
    return {s[4], 2'b00, s[5], s[3:0]};
  endfunction : sts_of
  task automatic wait_rtc(ref logic s);
    n = 0;
    while (s !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_rtc
  initial begin
    {cyc, error_cnt, compares} = '0;
    {psel, penable, pwrite, presetn, paddr, pwdata, src} = '0;
    pstrb = 4'hf;
    void'($urandom(32'hdb16));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", 12'h184, 8'h00);
    rchk("sts", 12'h190, 8'h00);
    rchk("en", 12'h198, 8'h00);
    apb(1'b0, 12'h000, 8'h00);
    chk("slverr", 32'(serr), 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h184, {2'($urandom), 1'b0, 3'(i), 2'($urandom)});
      rchk("ctrl", 12'h184, {3'h0, 3'(i), 2'h0});
    end
    rchk("sts", 12'h190, 8'h00);
    pstrb <= 4'h0;
    apb(1'b1, 12'h184, 8'h08);
    pstrb <= 4'hf;
    rchk("strb", 12'h184, 8'h14);
    apb(1'b1, 12'h198, 8'hff);
    rchk("en", 12'h198, 8'hbf);
    for (int i = 0; i < 4; i++) begin
      m = i ? $urandom % 64 : 63;
      @(posedge pclk);
      src <= m[5:0];
      repeat (3) @(posedge pclk);
      chk("smi", 32'(smi_n), 32'(m == 0));
      rchk("sts", 12'h190, sts_of(m[5:0]));
      t = $urandom % 256;
      apb(1'b1, 12'h190, t[7:0]);
      rchk("sts", 12'h190, sts_of(m[5:0]) & ~t[7:0]);
      apb(1'b1, 12'h190, 8'hff);
      src <= 6'h00;
      @(posedge pclk);
      chk("smi", 32'(smi_n), 32'h1);
    end
    // Diverted request must not sleep, and its event is masked at first
    apb(1'b1, 12'h188, 8'h01);
    apb(1'b1, 12'h184, 8'h3c);
    rchk("sts", 12'h190, 8'h20);
    repeat (1400) @(posedge pclk);
    chk("oe", 32'(oe_n), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, 12'h194, 8'h07);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, 12'h18c, 8'h07);
    apb(1'b1, 12'h188, 8'h00);
    apb(1'b1, 12'h190, 8'hff);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, 12'h184, 8'h24);
    wait_rtc(enter);
    chk("type", 32'(stype), 32'h1);
    chk("oe", 32'(oe_n), 32'h0);
    chk("dly", 32'(n > 620 && n < 1260), 32'h1);
    for (int k = 6; k < 8; k++) begin
      apb(1'b1, 12'h184, 8'h20 | 8'(k << 2));
      wait_rtc(oe_n);
      chk("dly", 32'(n > 620 && n < 1260), 32'h1);
      repeat (50) @(posedge pclk);
      chk("oe", 32'(oe_n), 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
    end
    tally_and_finish();
  end
endmodule : scsg_sleep_control_tb
`default_nettype wire
